// ### pkg/abre_pkg.sv
package abre_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [7:0] ADDR_BRIDGE_CONTROL = 8'h3E;
  localparam logic [7:0] ADDR_ERROR_COMMAND  = 8'h40;
  localparam logic [7:0] ADDR_IO_WINDOW      = 8'h1C;
  localparam logic [7:0] ADDR_MEM_WINDOW     = 8'h20;
  localparam logic [7:0] ADDR_PREF_WINDOW    = 8'h24;
  localparam logic [7:0] ADDR_BRIDGE_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h64;

  // Bridge control, error command and bridge command field positions.
  localparam int BCTL_B2B_EN_BIT  = 7;
  localparam int BCTL_SECONDARY_BUS_RESET_BIT_BIT  = 6;
  localparam int BCTL_MASTER_ABORT_MODE_BIT  = 5;
  localparam int BCTL_VIDEO_BIT   = 3;
  localparam int BCTL_ISA_BIT     = 2;
  localparam int BCTL_PARITY_BIT  = 0;
  localparam int ERRCMD_TA_BIT    = 0;
  localparam int CMD_ERR_MSG_BIT  = 8;

  // Reset values.
  localparam logic [7:0]  BRIDGE_CONTROL_RST = 8'h00;
  localparam logic [7:0]  ERROR_COMMAND_RST  = 8'h00;
  localparam logic [11:0] WIN_BASE_RST       = 12'hFFF;
  localparam logic [11:0] WIN_LIMIT_RST      = 12'h000;
  localparam logic [3:0]  IO_BASE_RST        = 4'hF;
  localparam logic [3:0]  IO_LIMIT_RST       = 4'h0;

  // Legacy video decode ranges and the lower bound of the alias filter.
  localparam logic [31:0] VIDEO_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] VIDEO_MEM_HI = 32'h000B_FFFF;
  localparam logic [9:0]  VIDEO_IO1_LO = 10'h3B0;
  localparam logic [9:0]  VIDEO_IO1_HI = 10'h3BB;
  localparam logic [9:0]  VIDEO_IO2_LO = 10'h3C0;
  localparam logic [9:0]  VIDEO_IO2_HI = 10'h3DF;
  localparam logic [9:0]  ISA_ALIAS_LO = 10'h100;

  // Interrupt status bit positions.
  localparam int IRQ_ERR_MSG_BIT  = 0;
  localparam int IRQ_MABORT_BIT   = 1;
  localparam int IRQ_TABORT_BIT   = 2;
  localparam int IRQ_PARITY_BIT   = 3;
  localparam int IRQ_WIDTH        = 4;

  // Transfer modes of the graphics port.
  typedef enum logic [1:0] {
    ABRE_MODE_1X,
    ABRE_MODE_2X,
    ABRE_MODE_4X
  } abre_mode_t;

  localparam logic [31:0] ALL_ONES_DATA = 32'hFFFF_FFFF;

endpackage

// ### hdl/abre_route_err_ctrl.sv
`timescale 1ns/10ps
module abre_route_err_ctrl (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [7:0]                 avs_address_in,
  input  wire logic                       avs_read_in,
  input  wire logic                       avs_write_in,
  input  wire logic [31:0]                avs_writedata_in,
  input  wire logic [3:0]                 avs_byteenable_in,
  output logic      [31:0]                avs_readdata_out,
  output logic                            avs_waitrequest_out,
  input  wire logic                       req_valid_in,
  input  wire logic                       req_is_io_in,
  input  wire logic [31:0]                req_addr_in,
  output logic                            route_valid_out,
  output logic                            route_to_graphics_out,
  input  wire abre_pkg::abre_mode_t       xfer_mode_in,
  output logic                            back_to_back_cycles_out,
  input  wire logic                       mabort_in,
  input  wire logic                       mabort_is_read_in,
  input  wire logic [31:0]                port_rdata_in,
  output logic      [31:0]                host_rdata_out,
  output logic                            write_data_drop_out,
  input  wire logic                       addr_parity_err_in,
  input  wire logic                       data_parity_err_in,
  input  wire logic                       target_abort_in,
  output logic                            error_message_out,
  output logic                            graphics_reset_n_out,
  output logic                            irq_out
);
  import abre_pkg::*;

  logic [7:0]           bctl_q;
  logic [7:0]           errcmd_q;
  logic [15:0]          cmd_q;
  logic [3:0]           io_base_q;
  logic [3:0]           io_limit_q;
  logic [11:0]          mem_base_q;
  logic [11:0]          mem_limit_q;
  logic [11:0]          pref_base_q;
  logic [11:0]          pref_limit_q;
  logic [IRQ_WIDTH-1:0] irq_stat_q;
  logic [IRQ_WIDTH-1:0] irq_mask_q;
  logic                 ack_q;
  logic [31:0]          rdata_d;
  logic [IRQ_WIDTH-1:0] irq_event;
  logic                 bus_req;
  logic                 wr_fire;
  logic                 video_on;
  logic                 isa_on;
  logic                 parity_on;
  logic                 in_io_win;
  logic                 in_mem_win;
  logic                 video_hit;
  logic                 isa_alias;
  logic                 err_parity;
  logic                 err_tabort;

  // Register bus handshake.
  // A request is never answered in the cycle it first appears. The first held
  // cycle lets the read mux settle into the read data register, so the data
  // stands in a flip-flop at the edge where waitrequest is seen low.
  // The cost is one wait state on every access, reads and writes alike.
  // Writes use the same timing so that software sees one uniform latency.
  // One wait state: every request is answered on the second cycle it is held.
  assign bus_req             = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign wr_fire             = avs_write_in & ack_q;

  // A master that holds its request past the acknowledge would otherwise
  // see a second completion; toggling keeps back-to-back requests at two
  // cycles each and never lets one held request land twice.
  // Acknowledge toggles so each held request completes exactly once.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Bridge control holds only three writable bits: legacy video routing,
  // the alias filter and parity reporting. The fast back-to-back enable,
  // the secondary bus reset bit and the master abort mode bit always read
  // zero; writing ones to them has no effect at all, so software cannot
  // reset the graphics port or change abort handling from here.
  // The error command register keeps only its target-abort enable bit.
  // The global error message enable sits in bit 8 of the bridge command.
  // Control bits that are hardwired to zero are masked off on write.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bctl_q   <= BRIDGE_CONTROL_RST;
      errcmd_q <= ERROR_COMMAND_RST;
      cmd_q    <= 16'h0000;
    end else if (wr_fire && avs_byteenable_in[0]) begin
      unique case (avs_address_in)
        ADDR_BRIDGE_CONTROL: begin
          bctl_q <= 8'h00;
          bctl_q[BCTL_VIDEO_BIT]  <= avs_writedata_in[BCTL_VIDEO_BIT];
          bctl_q[BCTL_ISA_BIT]    <= avs_writedata_in[BCTL_ISA_BIT];
          bctl_q[BCTL_PARITY_BIT] <= avs_writedata_in[BCTL_PARITY_BIT];
        end
        ADDR_ERROR_COMMAND: begin
          errcmd_q <= {7'h00, avs_writedata_in[ERRCMD_TA_BIT]};
        end
        ADDR_BRIDGE_COMMAND: begin
          cmd_q[7:0] <= avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) begin
            cmd_q[15:8] <= avs_writedata_in[15:8];
          end
        end
        default: begin
        end
      endcase
    end else if (wr_fire && avs_byteenable_in[1] && avs_address_in == ADDR_BRIDGE_COMMAND) begin
      cmd_q[15:8] <= avs_writedata_in[15:8];
    end
  end

  // The I/O window compares address bits 15 to 12, giving 4 KB granularity.
  // The memory windows compare address bits 31 to 20: the base acts as if
  // its low bits were zero and the limit as if they were all ones, so each
  // window covers whole 1 MB blocks, limits included.
  // Reset values leave every window empty (base above limit), so nothing
  // is forwarded to the graphics port until software opens a window or turns on legacy video routing.
  // Memory windows need all four lanes so that base and limit change together.
  // Window registers: I/O base/limit in bits 7:4 and 15:12, memory in 15:4 / 31:20.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_base_q    <= IO_BASE_RST;
      io_limit_q   <= IO_LIMIT_RST;
      mem_base_q   <= WIN_BASE_RST;
      mem_limit_q  <= WIN_LIMIT_RST;
      pref_base_q  <= WIN_BASE_RST;
      pref_limit_q <= WIN_LIMIT_RST;
    end else if (wr_fire) begin
      if (avs_address_in == ADDR_IO_WINDOW) begin
        if (avs_byteenable_in[0]) io_base_q  <= avs_writedata_in[7:4];
        if (avs_byteenable_in[1]) io_limit_q <= avs_writedata_in[15:12];
      end
      if (avs_address_in == ADDR_MEM_WINDOW && avs_byteenable_in == 4'hF) begin
        mem_base_q  <= avs_writedata_in[15:4];
        mem_limit_q <= avs_writedata_in[31:20];
      end
      if (avs_address_in == ADDR_PREF_WINDOW && avs_byteenable_in == 4'hF) begin
        pref_base_q  <= avs_writedata_in[15:4];
        pref_limit_q <= avs_writedata_in[31:20];
      end
    end
  end

  // Reserved low bits of every window register read back as zero.
  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address_in)
      ADDR_BRIDGE_CONTROL: rdata_d = {24'h000000, bctl_q};
      ADDR_ERROR_COMMAND:  rdata_d = {24'h000000, errcmd_q};
      ADDR_BRIDGE_COMMAND: rdata_d = {16'h0000, cmd_q};
      ADDR_IO_WINDOW:      rdata_d = {16'h0000, io_limit_q, 4'h0, io_base_q, 4'h0};
      ADDR_MEM_WINDOW:     rdata_d = {mem_limit_q, 4'h0, mem_base_q, 4'h0};
      ADDR_PREF_WINDOW:    rdata_d = {pref_limit_q, 4'h0, pref_base_q, 4'h0};
      ADDR_IRQ_STATUS:     rdata_d = {28'h0000000, irq_stat_q};
      ADDR_IRQ_MASK:       rdata_d = {28'h0000000, irq_mask_q};
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  // The register loads only while the acknowledge is low, so the value
  // captured in the first held cycle stays put through the answering edge.
  // Read data is registered on the cycle before the acknowledging edge.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      avs_readdata_out <= rdata_d;
    end
  end

  // The decode is purely combinational on the request inputs; the result
  // is registered below, so routing appears one cycle after a request.
  // The alias filter marks the upper 768 bytes of every 1 KB block, that
  // is, any I/O address whose low ten bits are at or above 100h.
  // Address decode for host-initiated requests.
  assign video_on  = bctl_q[BCTL_VIDEO_BIT];
  assign isa_on    = bctl_q[BCTL_ISA_BIT];
  assign parity_on = bctl_q[BCTL_PARITY_BIT];
  assign in_io_win = (req_addr_in[15:12] >= io_base_q) &&
                     (req_addr_in[15:12] <= io_limit_q);
  assign in_mem_win = ((req_addr_in[31:20] >= mem_base_q) &&
                       (req_addr_in[31:20] <= mem_limit_q)) ||
                      ((req_addr_in[31:20] >= pref_base_q) &&
                       (req_addr_in[31:20] <= pref_limit_q));
  assign isa_alias = (req_addr_in[9:0] >= ISA_ALIAS_LO);

  // Address bits 15 to 10 are not looked at for I/O, so every alias of the
  // legacy video ports matches as well.
  // Legacy video ranges; I/O decodes only the low ten bits.
  always_comb begin
    if (req_is_io_in) begin
      video_hit = ((req_addr_in[9:0] >= VIDEO_IO1_LO) && (req_addr_in[9:0] <= VIDEO_IO1_HI)) ||
                  ((req_addr_in[9:0] >= VIDEO_IO2_LO) && (req_addr_in[9:0] <= VIDEO_IO2_HI));
    end else begin
      video_hit = (req_addr_in >= VIDEO_MEM_LO) && (req_addr_in <= VIDEO_MEM_HI);
    end
  end

  // Priority of the routing decision:
  // legacy video routing, when on, wins over windows and the alias filter;
  // otherwise I/O follows the I/O window minus filtered aliases;
  // otherwise memory follows the two memory windows.
  // With video routing off, legacy ranges fall through to the windows and
  // end on primary PCI unless a window covers them.
  // Routing decision, registered; a low result means primary PCI.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_valid_out       <= 1'b0;
      route_to_graphics_out <= 1'b0;
    end else begin
      route_valid_out <= req_valid_in;
      if (video_on && video_hit) begin
        route_to_graphics_out <= 1'b1;
      end else if (req_is_io_in) begin
        route_to_graphics_out <= in_io_win && !(isa_on && isa_alias);
      end else begin
        route_to_graphics_out <= in_mem_win;
      end
    end
  end

  // Only one target sits on the graphics port, so the enable bit in bridge
  // control is meaningless and reads zero; the mode alone decides.
  // In 1x mode no back-to-back cycles are issued; 2x and 4x allow them.
  // Back-to-back issue depends only on transfer mode, never on a register bit.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      back_to_back_cycles_out <= 1'b0;
    end else begin
      back_to_back_cycles_out <= (xfer_mode_in != ABRE_MODE_1X);
    end
  end

  // The abort handling is fixed: there is no mode bit to change it.
  // Read data from the port is passed through unless the transfer aborted.
  // Master abort: reads return all ones, writes are dropped.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_rdata_out      <= 32'h0000_0000;
      write_data_drop_out <= 1'b0;
    end else begin
      host_rdata_out      <= mabort_in ? ALL_ONES_DATA : port_rdata_in;
      write_data_drop_out <= mabort_in && !mabort_is_read_in;
    end
  end

  // Address and data parity errors report only with parity reporting on.
  // Target aborts report only with the target-abort enable on.
  // Both kinds pass the global enable last, so clearing it silences all.
  // There is no parity error pin; raw parity errors also set the interrupt status parity bit.
  // Error messages, all behind the global enable.
  assign err_parity = (addr_parity_err_in | data_parity_err_in) & parity_on;
  assign err_tabort = target_abort_in & errcmd_q[ERRCMD_TA_BIT];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      error_message_out <= 1'b0;
    end else begin
      error_message_out <= (err_parity | err_tabort) & cmd_q[CMD_ERR_MSG_BIT];
    end
  end

  // No register can assert this output: it is low only while the system
  // reset is low, whether that reset came from software or hardware.
  // The graphics port reset follows only the system reset.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      graphics_reset_n_out <= 1'b0;
    end else begin
      graphics_reset_n_out <= 1'b1;
    end
  end

  // Status bits: error message sent, master abort, target abort and raw
  // parity error. Parity is recorded even when reporting is off, so that
  // software can still see it by polling.
  // A write of one clears a bit; an event in the same cycle keeps it set,
  // so no event can be lost to a clear that races it.
  // Sticky interrupt status; a new event wins over a write-one clear.
  assign irq_event[IRQ_ERR_MSG_BIT] = error_message_out;
  assign irq_event[IRQ_MABORT_BIT]  = mabort_in;
  assign irq_event[IRQ_TABORT_BIT]  = target_abort_in;
  assign irq_event[IRQ_PARITY_BIT]  = addr_parity_err_in | data_parity_err_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr_fire && avs_byteenable_in[0] && avs_address_in == ADDR_IRQ_STATUS) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata_in[IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_stat_q <= irq_stat_q | irq_event;
      end
      if (wr_fire && avs_byteenable_in[0] && avs_address_in == ADDR_IRQ_MASK) begin
        irq_mask_q <= avs_writedata_in[IRQ_WIDTH-1:0];
      end
    end
  end

  // The mask resets to zero, so the interrupt stays low until enabled.
  // Level interrupt while any unmasked status bit is set.
  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule

// ### dv/abre_gfx_target.sv
`timescale 1ns/10ps
// Far-side graphics target: each command code gives a one-cycle registered answer.
module abre_gfx_target (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  cmd_in,
  input  wire logic [31:0] data_in,
  output logic             mabort_out,
  output logic             is_read_out,
  output logic [31:0]      rdata_out,
  output logic             addr_perr_out,
  output logic             data_perr_out,
  output logic             tabort_out
);
  // Codes: 1 read, 2 aborted read, 3 aborted write, 4 target abort, 5 and 6 parity faults.
  // Undriven read data shows the inverse of its last value, so nothing stale can pass.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {mabort_out, is_read_out, addr_perr_out, data_perr_out, tabort_out} <= 5'h00;
      rdata_out <= 32'h0;
    end else begin
      mabort_out    <= cmd_in inside {3'h2, 3'h3};
      is_read_out   <= cmd_in inside {3'h1, 3'h2};
      tabort_out    <= cmd_in == 3'h4;
      addr_perr_out <= cmd_in == 3'h5;
      data_perr_out <= cmd_in == 3'h6;
      rdata_out     <= (cmd_in == 3'h1) ? data_in : ~rdata_out;
    end
  end
endmodule

// ### dv/abre_route_err_checker.sv
`timescale 1ns/10ps
// Watches the bus handshake, abort data, transfer mode and error timing at the ports.
module abre_route_err_checker (
  input wire logic                 ref_clk_in,
  input wire logic                 rst_n_in,
  input wire logic [7:0]           avs_address_in,
  input wire logic                 avs_read_in,
  input wire logic                 avs_write_in,
  input wire logic [31:0]          avs_readdata_out,
  input wire logic                 avs_waitrequest_out,
  input wire abre_pkg::abre_mode_t xfer_mode_in,
  input wire logic                 back_to_back_cycles_out,
  input wire logic                 mabort_in,
  input wire logic                 mabort_is_read_in,
  input wire logic [31:0]          port_rdata_in,
  input wire logic [31:0]          host_rdata_out,
  input wire logic                 write_data_drop_out,
  input wire logic                 addr_parity_err_in,
  input wire logic                 data_parity_err_in,
  input wire logic                 target_abort_in,
  input wire logic                 error_message_out,
  input wire logic                 graphics_reset_n_out
);
  import abre_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // A fresh request starts stalled; a read of the control register ends on its ack.
  sequence s_req_open;
    $rose(avs_read_in || avs_write_in) ##0 avs_waitrequest_out;
  endsequence
  sequence s_ctrl_ack;
    avs_read_in && !avs_waitrequest_out && avs_address_in == ADDR_BRIDGE_CONTROL;
  endsequence
  a_bus_ack_next:
    assert property (s_req_open |=> !avs_waitrequest_out)
    else $error("bus ack late");
  a_ctrl_fixed_bits:
    assert property (s_ctrl_ack |-> avs_readdata_out[7:5] == 3'h0)
    else $error("control bits 7 to 5 not zero");
  a_b2b_by_mode:
    assert property (1'b1 |=> back_to_back_cycles_out == ($past(xfer_mode_in) != ABRE_MODE_1X))
    else $error("back to back wrong for mode");
  a_abort_all_ones:
    assert property (mabort_in |=> host_rdata_out == ALL_ONES_DATA)
    else $error("abort read data not all ones");
  a_read_passes:
    assert property (!mabort_in |=> host_rdata_out == $past(port_rdata_in))
    else $error("read data not passed");
  a_write_dropped:
    assert property (1'b1 |=> write_data_drop_out == ($past(mabort_in) && !$past(mabort_is_read_in)))
    else $error("write drop wrong");
  a_err_has_cause:
    assert property (error_message_out |->
      $past(addr_parity_err_in) || $past(data_parity_err_in) || $past(target_abort_in))
    else $error("error message without cause");
  a_port_reset_held:
    assert property (1'b1 |=> graphics_reset_n_out)
    else $error("graphics reset outside system reset");
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
// Drives bus, host requests and the far-side target, comparing each result with a model.
module testbench;
  import abre_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rv = 1'b0, io = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [2:0] cmd = 3'h0;
  logic [31:0] wd = 32'h0, rq = 32'h0, pdi = 32'h0, rdv, pd, hrd, bc, ec, cm, e_hd;
  abre_mode_t md = ABRE_MODE_1X;
  logic ws, rvo, rgo, b2b, ma, mr, ape, dpe, ta, drop, em, grn, irq;
  logic e_rv, e_rt, e_bb, e_wd, e_em;
  integer seed = 32'hA8B4B678;
  int mismatches = 0, checks_done = 0;
  abre_route_err_ctrl dut (.ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdv), .avs_waitrequest_out(ws), .req_valid_in(rv), .req_is_io_in(io),
    .req_addr_in(rq), .route_valid_out(rvo), .route_to_graphics_out(rgo), .xfer_mode_in(md),
    .back_to_back_cycles_out(b2b), .mabort_in(ma), .mabort_is_read_in(mr),
    .port_rdata_in(pd), .host_rdata_out(hrd), .write_data_drop_out(drop),
    .addr_parity_err_in(ape), .data_parity_err_in(dpe), .target_abort_in(ta),
    .error_message_out(em), .graphics_reset_n_out(grn), .irq_out(irq));
  abre_gfx_target gfx (.ref_clk_in(clk), .rst_n_in(rst_n), .cmd_in(cmd), .data_in(pdi),
    .mabort_out(ma), .is_read_out(mr), .rdata_out(pd), .addr_perr_out(ape),
    .data_perr_out(dpe), .tabort_out(ta));
  // Free-running 125 MHz clock.
  initial forever #4 clk = ~clk;
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  // One bus access; waitrequest and read data are taken at the rising edge it is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (ws !== 1'b0 && n < 50);
    if (ws !== 1'b0) begin
      mismatches++;
      end_sim;
    end
    r = rdv;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  logic [31:0] wd_io, wd_mw, wd_pw;
  // Expected destination of a host request under the current control and windows.
  function automatic logic exp_route(logic isio, logic [31:0] a);
    if (isio)
      return (bc[3] && (a[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]}))
        || (a[15:12] >= wd_io[7:4] && a[15:12] <= wd_io[15:12] && !(bc[2] && a[9:0] >= 10'h100));
    return (bc[3] && a >= 32'h000A0000 && a <= 32'h000BFFFF)
      || (a[31:20] >= wd_mw[15:4] && a[31:20] <= wd_mw[31:20])
      || (a[31:20] >= wd_pw[15:4] && a[31:20] <= wd_pw[31:20]);
  endfunction
  // Main sequence: reset, fixed bits, random traffic per setup, then the interrupt.
  initial begin
    logic [31:0] r, t;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, ADDR_BRIDGE_CONTROL, 0, r);
    chk_word("bridge_control", 32'h0, r);
    bus(0, ADDR_ERROR_COMMAND, 0, r);
    chk_word("error_command", 32'h0, r);
    bus(1, ADDR_BRIDGE_CONTROL, 32'hFF, r);
    bus(0, ADDR_BRIDGE_CONTROL, 0, r);
    chk_word("bridge_control rw", 32'h0D, r & 32'hED);
    chk_bit("graphics_reset_n", 1'b1, grn);
    bus(0, 8'h80, 0, r);
    chk_word("unmapped", 32'h0, r);
    for (int g = 0; g < 12; g++) begin
      bc = $random(seed) & 32'h0D;
      ec = $random(seed) & 32'h01;
      cm = $random(seed) & 32'h100;
      wd_io = $random(seed) & 32'hF0F0;
      wd_mw = $random(seed) & 32'h00F000F0;
      wd_pw = $random(seed) & 32'h00F000F0;
      bus(1, ADDR_BRIDGE_CONTROL, bc, r);
      bus(1, ADDR_ERROR_COMMAND, ec, r);
      bus(1, ADDR_BRIDGE_COMMAND, cm, r);
      bus(1, ADDR_IO_WINDOW, wd_io, r);
      bus(1, ADDR_MEM_WINDOW, wd_mw, r);
      bus(1, ADDR_PREF_WINDOW, wd_pw, r);
      for (int k = 0; k < 41; k++) begin
        t = $random(seed);
        @(posedge clk);
        rv <= k < 40;
        io <= t[0];
        md <= abre_mode_t'(2'(t[9:1] % 3));
        cmd <= (k < 40) ? 3'(t[17:10] % 7) : 3'h0;
        rq <= $random(seed) & (t[0] ? 32'h0000FFFF : 32'h003FFFFF);
        pdi <= $random(seed);
        @(negedge clk);
        if (k > 0) begin
          chk_bit("route_valid", e_rv, rvo);
          if (e_rv) chk_bit("route_to_graphics", e_rt, rgo);
          chk_bit("back_to_back", e_bb, b2b);
          chk_word("host_rdata", e_hd, hrd);
          chk_bit("write_drop", e_wd, drop);
          chk_bit("error_message", e_em, em);
        end
        e_rv = rv;
        e_rt = exp_route(io, rq);
        e_bb = md != ABRE_MODE_1X;
        e_hd = ma ? 32'hFFFFFFFF : pd;
        e_wd = ma && !mr;
        e_em = cm[8] && ((bc[0] && (ape || dpe)) || (ec[0] && ta));
      end
    end
    bus(1, ADDR_IRQ_MASK, 32'h0, r);
    bus(1, ADDR_IRQ_STATUS, 32'hF, r);
    @(posedge clk) cmd <= 3'h4;
    @(posedge clk) cmd <= 3'h0;
    bus(0, ADDR_IRQ_STATUS, 0, r);
    chk_word("irq_status", 32'h4 | {31'h0, cm[8] & ec[0]}, r);
    chk_bit("irq masked", 1'b0, irq);
    bus(1, ADDR_IRQ_MASK, 32'h4, r);
    @(negedge clk);
    chk_bit("irq raised", 1'b1, irq);
    bus(1, ADDR_IRQ_STATUS, 32'h4, r);
    @(negedge clk);
    chk_bit("irq cleared", 1'b0, irq);
    end_sim;
  end
endmodule
bind abre_route_err_ctrl abre_route_err_checker u_chk (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .xfer_mode_in(xfer_mode_in),
  .back_to_back_cycles_out(back_to_back_cycles_out), .mabort_in(mabort_in),
  .mabort_is_read_in(mabort_is_read_in), .port_rdata_in(port_rdata_in),
  .host_rdata_out(host_rdata_out), .write_data_drop_out(write_data_drop_out),
  .addr_parity_err_in(addr_parity_err_in), .data_parity_err_in(data_parity_err_in),
  .target_abort_in(target_abort_in), .error_message_out(error_message_out),
  .graphics_reset_n_out(graphics_reset_n_out));
